// *** src/dib_dma.sv ***
`timescale 1ns/10ps
`include "dib_cfg.svh"
module dib_dma import dib_pkg::*; (
    input  wire logic        clk,       // System clock, 100 MHz.
    input  wire logic        srst,      // Synchronous reset, high.
    input  wire logic        ce,        // Clock enable.
    input  wire logic        psel,      // APB select.
    input  wire logic        penable,   // APB enable.
    input  wire logic        pwrite,    // APB direction.
    input  wire logic [7:0]  paddr,     // APB byte address.
    input  wire logic [31:0] pwdata,    // APB write data.
    output logic [31:0]      prdata,    // APB read data.
    output logic             pready,    // APB ready.
    output logic             pslverr,   // APB error.
    input  wire logic [31:0] di_data,   // Input port pins.
    input  wire logic        di_strobe, // Sample clock pin.
    output logic             sampling,  // Sampling active.
    output logic             irq,       // Interrupt, high level.
    dib_bus_if.dev           bus        // System bus master side.
);
    dib_dma_type q;
    dib_dma_type d;
    logic        f_wr_ready;
    logic        f_rd_valid;
    logic [31:0] f_rd_data;
    logic        push;
    logic        pop;
    logic        wr_acc;
    logic        done_ev;
    logic        ovr_ev;
    logic        stop_now;
    logic [1:0]  clr;
    logic [31:0] rd_mux;
    logic        hit;

    dib_fifo u_fifo (
        .clk      (clk),
        .srst     (srst),
        .ce       (ce),
        .flush    (q.flush),
        .wr_valid (push),
        .wr_data  (q.di_s2),
        .wr_ready (f_wr_ready),
        .rd_valid (f_rd_valid),
        .rd_data  (f_rd_data),
        .rd_ready (pop)
    );

    // The data lines pass the same two stages as the strobe, so the word
    // sampled on the strobe edge is the one present as the strobe rose;
    // this is safe for a source that holds the word across its strobe.
    assign push = q.stb_s2 && !q.stb_prev && q.sampling;

    always_comb begin
        d         = q;
        pop       = 1'b0;
        done_ev   = 1'b0;
        stop_now  = 1'b0;
        clr       = 2'h0;
        rd_mux    = 32'h0000_0000;
        hit       = 1'b1;
        d.flush   = 1'b0;
        d.di_s1   = di_data;
        d.di_s2   = q.di_s1;
        d.stb_s1  = di_strobe;
        d.stb_s2  = q.stb_s1;
        d.stb_prev = q.stb_s2;
        ovr_ev    = push && !f_wr_ready && !q.flush;

        if (paddr == `DIB_REG_CTRL) begin
            rd_mux = {27'h0, q.stop_sel, 1'b0, q.chain, 2'h0};
        end else if (paddr == `DIB_REG_ADDR) begin
            rd_mux = q.addr;
        end else if (paddr == `DIB_REG_COUNT) begin
            rd_mux = {8'h00, q.count};
        end else if (paddr == `DIB_REG_STATUS) begin
            rd_mux = {28'h0, q.sampling, q.int_stat[`DIB_IRQ_OVR],
                      q.int_stat[`DIB_IRQ_DONE], q.busy};
        end else if (paddr == `DIB_REG_INT_STAT) begin
            rd_mux = {30'h0, q.int_stat};
        end else if (paddr == `DIB_REG_INT_MASK) begin
            rd_mux = {30'h0, q.int_mask};
        end else begin
            hit = 1'b0;
        end

        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        if (psel && !penable) begin
            d.pready  = 1'b1;
            d.prdata  = pwrite ? 32'h0000_0000 : rd_mux;
            d.pslverr = !hit;
        end
        wr_acc = psel && penable && pwrite && q.pready && !q.pslverr;

        if (wr_acc) begin
            if (paddr == `DIB_REG_CTRL) begin
                d.chain    = pwdata[`DIB_CTRL_CHAIN];
                d.stop_sel = pwdata[`DIB_CTRL_STOP];
                if (pwdata[`DIB_CTRL_ABORT] && q.busy) begin
                    d.abort_pend = 1'b1;
                end
            end else if (paddr == `DIB_REG_ADDR) begin
                d.addr = pwdata;
            end else if (paddr == `DIB_REG_COUNT) begin
                d.count = pwdata[23:0];
            end else if (paddr == `DIB_REG_INT_STAT) begin
                clr = pwdata[1:0];
            end else if (paddr == `DIB_REG_INT_MASK) begin
                d.int_mask = pwdata[1:0];
            end
        end

        case (q.state)
            DIB_IDLE: begin
                if (wr_acc && paddr == `DIB_REG_CTRL &&
                    pwdata[`DIB_CTRL_START]) begin
                    d.busy     = 1'b1;
                    d.sampling = 1'b1;
                    d.flush    = pwdata[`DIB_CTRL_FLUSH];
                    d.idx      = `DIB_DESC_BUF;
                    if (pwdata[`DIB_CTRL_CHAIN]) begin
                        d.ptr   = q.addr & `DIB_DESC_ALIGN;
                        d.state = DIB_DESC;
                    end else begin
                        d.baddr = {q.addr[31:2], 2'b00};
                        d.words = dib_words(q.count);
                        d.ptr   = 32'h0000_0000;
                        if (dib_words(q.count) == 22'h0) begin
                            done_ev = 1'b1;
                        end else begin
                            d.state = DIB_XFER;
                        end
                    end
                end
            end
            DIB_DESC: begin
                if (q.abort_pend && !q.valid) begin
                    stop_now = 1'b1;
                end else begin
                    d.req = 1'b1;
                    if (!q.valid && bus.gnt && q.req) begin
                        d.valid = 1'b1;
                        d.we    = 1'b0;
                        d.baddr = q.ptr + {28'h0, q.idx, 2'b00};
                    end
                    if (q.valid && bus.ready) begin
                        d.valid = 1'b0;
                        d.idx   = q.idx + 2'h1;
                        if (q.idx == `DIB_DESC_BUF) begin
                            d.buf_addr = {bus.rdata[31:2], 2'b00};
                        end else if (q.idx == `DIB_DESC_LEN) begin
                            d.words = dib_words(bus.rdata[23:0]);
                        end else begin
                            d.idx   = `DIB_DESC_BUF;
                            d.ptr   = bus.rdata & `DIB_DESC_ALIGN;
                            d.baddr = q.buf_addr;
                            if (q.words != 22'h0) begin
                                d.state = DIB_XFER;
                            end else if (d.ptr == 32'h0000_0000) begin
                                done_ev = 1'b1;
                            end
                        end
                    end
                end
            end
            DIB_XFER: begin
                if (q.abort_pend && !q.valid) begin
                    stop_now = 1'b1;
                end else if (q.valid) begin
                    if (bus.ready) begin
                        d.valid = 1'b0;
                        d.baddr = q.baddr + `DIB_BEAT_BYTES;
                        d.words = q.words - 22'h1;
                        if (q.words == 22'h1) begin
                            if (q.chain && q.ptr != 32'h0000_0000) begin
                                d.state = DIB_DESC;
                            end else begin
                                done_ev = 1'b1;
                            end
                        end
                    end
                end else if (f_rd_valid) begin
                    d.req = 1'b1;
                    // A grant left over from a request that has just
                    // fallen is not used; the beat waits for a new one.
                    if (bus.gnt && q.req) begin
                        pop     = 1'b1;
                        d.valid = 1'b1;
                        d.we    = 1'b1;
                        d.wdata = f_rd_data;
                    end
                end else begin
                    d.req = 1'b0;
                end
            end
            default: begin
                stop_now = 1'b1;
            end
        endcase

        if (done_ev || stop_now) begin
            d.state      = DIB_IDLE;
            d.busy       = 1'b0;
            d.req        = 1'b0;
            d.valid      = 1'b0;
            d.abort_pend = 1'b0;
        end
        if (done_ev && q.stop_sel) begin
            d.sampling = 1'b0;
        end
        // A new event wins over a clear written in the same cycle.
        d.int_stat = (q.int_stat & ~clr) | {ovr_ev, done_ev};
        d.irq      = |(d.int_stat & d.int_mask);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q       <= '0;
            q.state <= DIB_IDLE;
        end else if (ce) begin
            q <= d;
        end
    end

    assign prdata    = q.prdata;
    assign pready    = q.pready;
    assign pslverr   = q.pslverr;
    assign sampling  = q.sampling;
    assign irq       = q.irq;
    assign bus.req   = q.req;
    assign bus.valid = q.valid;
    assign bus.we    = q.we;
    assign bus.addr  = q.baddr;
    assign bus.wdata = q.wdata;
endmodule : dib_dma

// *** src/dib_cfg.svh ***
// Summary of operation
// - Length given in bytes, up to 2^24 - 1.
// - Every beat moves one 32-bit longword.
// - Software loads length and start address first.
// - Keep draining FIFO until length is exhausted.
// - Release bus when FIFO is empty.
// - Drive bus only under grant; host owns priority.
// - Completion sets polled bit and optional interrupt.
// - Stop on last word or on abort.
// - Scatter-gather follows a chain of descriptors.
// - Descriptor pointers are 16-byte aligned.
// - Contiguous buffer is longword aligned.
// - Count is zero in chain mode; descriptors give length.
// - Flush select one empties FIFO before sampling.
// - Stop-on-done one halts sampling at completion; a zero-length block start uses the stop select of the previous control write.
// - Transfer status reads one while busy, zero done.
// - Push into full FIFO sets sticky overrun.
`ifndef DIB_CFG_SVH
`define DIB_CFG_SVH
`define DIB_FIFO_DEPTH   16
`define DIB_FIFO_AW      4
`define DIB_REG_CTRL     8'h00
`define DIB_REG_ADDR     8'h04
`define DIB_REG_COUNT    8'h08
`define DIB_REG_STATUS   8'h0c
`define DIB_REG_INT_STAT 8'h10
`define DIB_REG_INT_MASK 8'h14
`define DIB_CTRL_START   0
`define DIB_CTRL_ABORT   1
`define DIB_CTRL_CHAIN   2
`define DIB_CTRL_FLUSH   3
`define DIB_CTRL_STOP    4
`define DIB_IRQ_DONE     0
`define DIB_IRQ_OVR      1
`define DIB_DESC_BUF     2'h0
`define DIB_DESC_LEN     2'h1
`define DIB_DESC_NEXT    2'h2
`define DIB_DESC_ALIGN   32'hffff_fff0
`define DIB_BEAT_BYTES   32'h0000_0004
`endif

// *** src/dib_pkg.sv ***
package dib_pkg;
    typedef enum logic [2:0] {
        DIB_IDLE = 3'h1,
        DIB_DESC = 3'h2,
        DIB_XFER = 3'h4
    } dib_state_type;

    typedef struct packed {
        dib_state_type state;
        logic          busy;
        logic          sampling;
        logic          abort_pend;
        logic          chain;
        logic          stop_sel;
        logic          flush;
        logic [31:0]   addr;
        logic [23:0]   count;
        logic [31:0]   ptr;
        logic [31:0]   buf_addr;
        logic [21:0]   words;
        logic [1:0]    idx;
        logic          req;
        logic          valid;
        logic          we;
        logic [31:0]   baddr;
        logic [31:0]   wdata;
        logic [1:0]    int_stat;
        logic [1:0]    int_mask;
        logic          irq;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
        logic [31:0]   di_s1;
        logic [31:0]   di_s2;
        logic          stb_s1;
        logic          stb_s2;
        logic          stb_prev;
    } dib_dma_type;

    typedef struct packed {
        logic [15:0][31:0] mem;
        logic [4:0]        wptr;
        logic [4:0]        rptr;
    } dib_fifo_type;

    typedef struct packed {
        logic        gnt;
        logic        ready;
        logic        busy;
        logic [31:0] rdata;
        logic        mem_wr;
        logic        mem_rd;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
    } dib_host_type;

    // Rounds a byte count down to whole longwords.
    function automatic logic [21:0] dib_words(input logic [23:0] bytes);
        return bytes[23:2];
    endfunction : dib_words
endpackage : dib_pkg

// *** src/dib_bus_if.sv ***
`timescale 1ns/10ps
interface dib_bus_if;
    logic        req;
    logic        gnt;
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        ready;
    logic [31:0] rdata;

    modport dev  (output req, valid, we, addr, wdata,
                  input  gnt, ready, rdata);
    modport host (input  req, valid, we, addr, wdata,
                  output gnt, ready, rdata);
endinterface : dib_bus_if

// *** src/dib_fifo.sv ***
`timescale 1ns/10ps
`include "dib_cfg.svh"
module dib_fifo import dib_pkg::*; (
    input  wire logic        clk,      // System clock.
    input  wire logic        srst,     // Synchronous reset.
    input  wire logic        ce,       // Clock enable.
    input  wire logic        flush,    // Empties the FIFO.
    input  wire logic        wr_valid, // Push request.
    input  wire logic [31:0] wr_data,  // Pushed word.
    output logic             wr_ready, // Not full.
    output logic             rd_valid, // Not empty.
    output logic [31:0]      rd_data,  // Head word.
    input  wire logic        rd_ready  // Pop request.
);
    dib_fifo_type q;
    dib_fifo_type d;
    logic [4:0]   used;

    assign used     = q.wptr - q.rptr;
    assign wr_ready = (used != 5'h10);
    assign rd_valid = (used != 5'h00);
    assign rd_data  = q.mem[q.rptr[3:0]];

    always_comb begin
        d = q;
        if (flush) begin
            d.rptr = q.wptr;
        end else begin
            if (wr_valid && wr_ready) begin
                d.mem[q.wptr[3:0]] = wr_data;
                d.wptr = q.wptr + 5'h01;
            end
            if (rd_ready && rd_valid) begin
                d.rptr = q.rptr + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule : dib_fifo

// *** src/dib_host.sv ***
`timescale 1ns/10ps
module dib_host import dib_pkg::*; (
    input  wire logic        clk,       // System clock, 100 MHz.
    input  wire logic        srst,      // Synchronous reset, high.
    input  wire logic        ce,        // Clock enable.
    input  wire logic        hold,      // Higher-priority bus demand.
    output logic             mem_wr,    // Memory write strobe.
    output logic             mem_rd,    // Memory read strobe.
    output logic [31:0]      mem_addr,  // Memory byte address.
    output logic [31:0]      mem_wdata, // Memory write data.
    input  wire logic [31:0] mem_rdata, // Memory read data.
    dib_bus_if.host          bus        // System bus target side.
);
    dib_host_type q;
    dib_host_type d;

    always_comb begin
        d        = q;
        d.ready  = 1'b0;
        d.mem_wr = 1'b0;
        d.mem_rd = 1'b0;
        if (q.busy) begin
            d.busy  = 1'b0;
            d.ready = 1'b1;
            d.rdata = mem_rdata;
        end else if (bus.valid && !q.ready) begin
            d.busy      = 1'b1;
            d.mem_wr    = bus.we;
            d.mem_rd    = !bus.we;
            d.mem_addr  = bus.addr;
            d.mem_wdata = bus.wdata;
        end
        // Under a higher demand the grant falls only at the edge that
        // ends a beat, the one edge at which the device cannot begin
        // another, so no beat ever starts after the grant is gone.
        d.gnt = bus.req && (!hold ||
                (q.gnt && !(bus.valid && q.ready)));
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign bus.gnt   = q.gnt;
    assign bus.ready = q.ready;
    assign bus.rdata = q.rdata;
    assign mem_wr    = q.mem_wr;
    assign mem_rd    = q.mem_rd;
    assign mem_addr  = q.mem_addr;
    assign mem_wdata = q.mem_wdata;
endmodule : dib_host

// *** tb/dib_bus_assertions.sv ***
`timescale 1ns/10ps
module dib_bus_assertions (
    input wire logic        clk,   // System clock.
    input wire logic        srst,  // Synchronous reset, high.
    input wire logic        req,   // Bus request.
    input wire logic        gnt,   // Bus grant.
    input wire logic        valid, // Beat valid.
    input wire logic        we,    // Beat direction.
    input wire logic [31:0] addr,  // Beat address.
    input wire logic [31:0] wdata, // Beat write data.
    input wire logic        ready  // Beat accepted.
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    valid_gnt_a: assert property (valid |-> gnt)
        else $error("beat driven without grant");
    beat_start_a: assert property ($rose(valid) |-> req && gnt)
        else $error("beat started without request and grant");
    beat_hold_a: assert property (valid && !ready |=> valid
        && $stable(addr) && $stable(we) && $stable(wdata))
        else $error("beat changed before ready");
    ready_time_a: assert property ($rose(valid) |-> !ready
        ##1 !ready ##1 ready)
        else $error("ready not two cycles after valid");
    ready_end_a: assert property (ready |=> !ready && !valid)
        else $error("beat not closed after ready");
    ready_beat_a: assert property (ready |-> valid)
        else $error("ready without a beat");
    gnt_kept_a: assert property (valid && !ready |=> gnt)
        else $error("grant dropped inside a beat");
    gnt_cause_a: assert property ($rose(gnt) |-> $past(req))
        else $error("grant without request");
    word_align_a: assert property (valid && we |-> addr[1:0] == 2'h0)
        else $error("write beat not longword aligned");
    desc_align_a: assert property (valid && !we |-> addr[1:0] == 2'h0
        && addr[3:2] != 2'h3)
        else $error("descriptor read off its 16-byte node");
endmodule : dib_bus_assertions

// *** tb/tb_digital_input_bus_master_dma.sv ***
`timescale 1ns/10ps
`include "dib_cfg.svh"
module tb_digital_input_bus_master_dma;
    logic        clk, srst, ce, psel, penable, pwrite, di_strobe, hold;
    logic        pready, pslverr, sampling, irq, mem_wr, mem_rd, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, di_data, mem_addr, mem_wdata, rd;
    logic [31:0] mem_rdata;
    logic [31:0] mem [0:63];
    int          fails, tests_run;

    dib_bus_if dib_bus_if_inst ();
    dib_dma dib_dma_inst (.clk(clk), .srst(srst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .di_data(di_data), .di_strobe(di_strobe), .sampling(sampling),
        .irq(irq), .bus(dib_bus_if_inst.dev));
    dib_host dib_host_inst (.clk(clk), .srst(srst), .ce(ce), .hold(hold),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .bus(dib_bus_if_inst.host));
    dib_bus_assertions dib_bus_assertions_inst (.clk(clk), .srst(srst),
        .req(dib_bus_if_inst.req), .gnt(dib_bus_if_inst.gnt),
        .valid(dib_bus_if_inst.valid), .we(dib_bus_if_inst.we),
        .addr(dib_bus_if_inst.addr), .wdata(dib_bus_if_inst.wdata),
        .ready(dib_bus_if_inst.ready));

    // Memory is combinational so read data is settled when the host samples.
    assign mem_rdata = mem[mem_addr[7:2]];
    always @(posedge clk) begin
        if (mem_wr)
            mem[mem_addr[7:2]] <= mem_wdata;
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize;
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Every signal moves just after a rising edge, and the answer is taken
    // at the rising edge at which pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        logic ok;
        ok = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge clk);
            ok = (pready === 1'b1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) begin
            fails++;
            summarize();
        end
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                        input string name);
        apb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask : rchk

    task automatic start(input logic [31:0] a, input logic [31:0] c,
                         input logic [31:0] ctl);
        apb(1'b1, `DIB_REG_ADDR, a);
        apb(1'b1, `DIB_REG_COUNT, c);
        apb(1'b1, `DIB_REG_CTRL, ctl);
        @(negedge clk);
    endtask : start

    task automatic push(input logic [31:0] d);
        @(posedge clk);
        di_data <= d;
        di_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        di_strobe <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : push

    task automatic wait_idle;
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++) begin
            apb(1'b0, `DIB_REG_STATUS, 32'h0);
            ok = (rd[0] === 1'b0);
        end
        @(negedge clk);
        if (!ok) begin
            fails++;
            summarize();
        end
    endtask : wait_idle

    initial begin
        srst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        di_data = 32'h0;
        di_strobe = 1'b0;
        hold = 1'b0;
        fails = 0;
        tests_run = 0;
        for (int i = 0; i < 64; i++)
            mem[i] = 32'h0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rchk(`DIB_REG_STATUS, 32'h0, "status reset");
        rchk(`DIB_REG_INT_MASK, 32'h0, "mask reset");
        check("irq reset", irq, 1'b0);
        check("sampling reset", sampling, 1'b0);
        check("req reset", dib_bus_if_inst.req, 1'b0);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped error", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        start(32'h0, 32'hc, 32'h19);
        check("sampling on", sampling, 1'b1);
        push(32'ha1a1_0001);
        // A higher-priority demand keeps the second word waiting in the FIFO.
        hold <= 1'b1;
        push(32'ha1a1_0002);
        hold <= 1'b0;
        push(32'ha1a1_0003);
        wait_idle();
        for (int i = 0; i < 3; i++)
            check("block word", mem[i], 32'ha1a1_0001 + i);
        rchk(`DIB_REG_STATUS, 32'h2, "status done");
        check("sampling stop", sampling, 1'b0);
        rchk(`DIB_REG_INT_STAT, 32'h1, "int done");
        check("irq masked", irq, 1'b0);
        apb(1'b1, `DIB_REG_INT_MASK, 32'h3);
        repeat (2) @(negedge clk);
        check("irq unmasked", irq, 1'b1);
        apb(1'b1, `DIB_REG_INT_STAT, 32'h1);
        repeat (2) @(negedge clk);
        check("irq cleared", irq, 1'b0);
        mem[16] = 32'h20;
        mem[17] = 32'h4;
        mem[18] = 32'h50;
        mem[20] = 32'h30;
        mem[21] = 32'h4;
        mem[22] = 32'h0;
        start(32'h40, 32'h0, 32'h05);
        rchk(`DIB_REG_CTRL, 32'h4, "ctrl chain");
        push(32'hb2b2_0001);
        push(32'hb2b2_0002);
        wait_idle();
        check("chain buf0", mem[8], 32'hb2b2_0001);
        check("chain buf1", mem[12], 32'hb2b2_0002);
        check("sampling kept", sampling, 1'b1);
        // Seventeen words into the sixteen-deep FIFO: the last one overruns.
        for (int i = 0; i < 17; i++)
            push(32'hc0c0_0000 + i);
        rchk(`DIB_REG_STATUS, 32'he, "status overrun");
        rchk(`DIB_REG_INT_STAT, 32'h3, "int overrun");
        check("irq overrun", irq, 1'b1);
        start(32'h80, 32'h40, 32'h01);
        wait_idle();
        for (int i = 0; i < 16; i++)
            check("kept word", mem[32 + i], 32'hc0c0_0000 + i);
        push(32'hdead_0001);
        start(32'h70, 32'h4, 32'h19);
        push(32'hd00d_0002);
        wait_idle();
        check("flushed start", mem[28], 32'hd00d_0002);
        check("sampling stop", sampling, 1'b0);
        apb(1'b1, `DIB_REG_INT_STAT, 32'h3);
        start(32'hc0, 32'h8, 32'h19);
        apb(1'b0, `DIB_REG_STATUS, 32'h0);
        check("busy", rd[0], 1'b1);
        apb(1'b1, `DIB_REG_CTRL, 32'h2);
        wait_idle();
        rchk(`DIB_REG_INT_STAT, 32'h0, "abort no done");
        check("abort no write", mem[48], 32'h0);
        summarize();
    end
endmodule : tb_digital_input_bus_master_dma
